// [fmc_map.svh]
// fmc_map.svh: offsets, field positions, reset values and timing counts
// assumes: included by fmc_config_regs.sv by bare name, not by fmc_pkg.sv
`ifndef FMC_MAP_SVH
`define FMC_MAP_SVH

`define FMC_OFS_PIN_TACH 8'h02
`define FMC_OFS_CHAN_SEL 8'h03
`define FMC_OFS_FAN_A_AUTO 8'h05
`define FMC_OFS_FAN_B_AUTO 8'h06
`define FMC_OFS_LOW_BITS 8'h08
`define FMC_OFS_IN_A_HIGH 8'h0a
`define FMC_OFS_IN_B_HIGH 8'h0b
`define FMC_OFS_SUPPLY_HIGH 8'h0c
`define FMC_OFS_REMOTE_HIGH 8'h0d

`define FMC_RST_PIN_TACH 8'hc0
`define FMC_RST_CHAN_SEL 6'h00
`define FMC_RST_FAN_AUTO 8'h0c
`define FMC_RST_READING 8'h00

`define FMC_PT_PIN_LO 0
`define FMC_PT_PIN_HI 1
`define FMC_PT_BOOST 2
`define FMC_PT_FAST 3
`define FMC_PT_CONT_A 4
`define FMC_PT_CONT_B 5
`define FMC_PT_THERMAL_ALARM_PIN_A 6
`define FMC_PT_THERMAL_ALARM_PIN_B 7
`define FMC_PT_UNLOCKED_MASK 8'h30

`define FMC_CS_CHAN_LO 0
`define FMC_CS_CHAN_HI 2
`define FMC_CS_SINGLE 3
`define FMC_CS_FLOOR_A 4
`define FMC_CS_FLOOR_B 5

`define FMC_AC_SRC_A 0
`define FMC_AC_SRC_B 1
`define FMC_AC_REMOTE 2
`define FMC_AC_ONCHIP 3
`define FMC_AC_DIRECT 4
`define FMC_AC_MIN 5
`define FMC_AC_SPINUP 6
`define FMC_AC_MAX 7

`define FMC_FULL_DUTY 8'hff
`define FMC_CLK_KHZ 40000
`define FMC_TACH_SLOW_MS 1000
`define FMC_TACH_FAST_MS 250
`define FMC_TACH_SLOW_CYC (`FMC_TACH_SLOW_MS * `FMC_CLK_KHZ)
`define FMC_TACH_FAST_CYC (`FMC_TACH_FAST_MS * `FMC_CLK_KHZ)
`define FMC_HIGH_ALL_READ 4'hf

`endif

// [fmc_pkg.sv]
// fmc_pkg.sv: types shared by the fan monitor configuration bank
// assumes: fmc_map.svh holds the offsets, field positions and reset values; the enum encodings are here
package fmc_pkg;
  typedef enum logic [1:0] {
    FMC_PIN_FAN_ON = 2'b00,
    FMC_PIN_ALARM = 2'b01,
    FMC_PIN_PROC_HOT = 2'b10
  } fmc_pin_t;

  typedef enum logic [2:0] {
    FMC_FAN_AUTO = 3'b000,
    FMC_FAN_DIRECT = 3'b001,
    FMC_FAN_MIN = 3'b010,
    FMC_FAN_SPINUP = 3'b011,
    FMC_FAN_MAX = 3'b100
  } fmc_fan_mode_t;
endpackage : fmc_pkg

// [fmc_config_regs.sv]
// fmc_config_regs.sv: configuration register group of the fan monitor
// assumes: serial host logic issues one-cycle read/write strobes on a byte port,
// lock and second-diode levels come from the first two configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "fmc_map.svh"

module fmc_config_regs
  import fmc_pkg::*;
#(
  parameter int unsigned TACH_SLOW_CYC = `FMC_TACH_SLOW_CYC,
  parameter int unsigned TACH_FAST_CYC = `FMC_TACH_FAST_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic globalLock,
  input wire logic second_diode_mode,
  input wire logic processor_hot_input,
  input wire logic [9:0] remoteReading,
  input wire logic [9:0] supplyReading,
  input wire logic [9:0] analogInputAReading,
  input wire logic [9:0] analogInputBReading,
  input wire logic [7:0] inputADemand,
  input wire logic [7:0] inputBDemand,
  input wire logic [7:0] remoteDemand,
  input wire logic [7:0] onchipDemand,
  input wire logic [7:0] fanAMinSpeed,
  input wire logic [7:0] fanBMinSpeed,
  input wire logic [7:0] fanASpinupSpeed,
  input wire logic [7:0] fanBSpinupSpeed,
  input wire logic [7:0] fan_a_drive_level,
  input wire logic [7:0] fan_b_drive_level,
  output logic fan_a_on_output_en,
  output logic thermal_alarm_pin_en,
  output logic processor_hot_input_en,
  output logic tachSampleStrb,
  output logic continuous_speed_sense_a,
  output logic continuous_speed_sense_b,
  output logic inputAThermistor,
  output logic inputBThermistor,
  output logic diodePairMode,
  output logic one_channel_conversion,
  output logic [2:0] single_conversion_channel,
  output logic [7:0] fanADuty,
  output logic [7:0] fanBDuty
);
  logic [7:0] pinTach_ff;
  logic [5:0] chanSel_ff;
  logic [7:0] fanAAuto_ff;
  logic [7:0] fanBAuto_ff;
  logic [7:0] lowBits_ff;
  logic [7:0] highInA_ff;
  logic [7:0] highInB_ff;
  logic [7:0] highSupply_ff;
  logic [7:0] highRemote_ff;
  logic frozen_ff;
  logic [3:0] highRead_ff;
  logic [31:0] tachCnt_ff;
  logic procHotActive;
  logic [7:0] nxt_fanADuty;
  logic [7:0] nxt_fanBDuty;
  logic [7:0] nxt_regRdData;
  logic [3:0] nxt_highRead;
  logic srcAValid;
  logic srcBValid;
  logic [31:0] tachPeriod;

  function automatic fmc_fan_mode_t fanMode(input logic [7:0] ctl);
    if (ctl[`FMC_AC_MAX]) fanMode = FMC_FAN_MAX;
    else if (ctl[`FMC_AC_SPINUP]) fanMode = FMC_FAN_SPINUP;
    else if (ctl[`FMC_AC_MIN]) fanMode = FMC_FAN_MIN;
    else if (ctl[`FMC_AC_DIRECT]) fanMode = FMC_FAN_DIRECT;
    else fanMode = FMC_FAN_AUTO;
  endfunction : fanMode

  function automatic logic [7:0] fanDuty(input logic [7:0] ctl, input logic [7:0] minSpd,
      input logic [7:0] spinSpd, input logic [7:0] drive, input logic floorOn);
    logic [7:0] autoDuty;
    logic [7:0] duty;
    autoDuty = 8'h00;
    // input 1 as thermistor or diode
    if (ctl[`FMC_AC_SRC_A] && srcAValid && inputADemand > autoDuty) autoDuty = inputADemand;
    if (ctl[`FMC_AC_SRC_B] && srcBValid && inputBDemand > autoDuty) autoDuty = inputBDemand;
    if (ctl[`FMC_AC_REMOTE] && remoteDemand > autoDuty) autoDuty = remoteDemand;
    if (ctl[`FMC_AC_ONCHIP] && onchipDemand > autoDuty) autoDuty = onchipDemand;
    case (fanMode(ctl))
      FMC_FAN_MAX: duty = `FMC_FULL_DUTY;
      FMC_FAN_SPINUP: duty = spinSpd;
      FMC_FAN_MIN: duty = minSpd;
      FMC_FAN_DIRECT: duty = drive;
      default: duty = autoDuty;
    endcase
    if (floorOn && duty < minSpd) duty = minSpd;
    fanDuty = duty;
  endfunction : fanDuty

  assign srcAValid = pinTach_ff[`FMC_PT_THERMAL_ALARM_PIN_A] || second_diode_mode;
  assign srcBValid = pinTach_ff[`FMC_PT_THERMAL_ALARM_PIN_B] && !second_diode_mode;
  assign procHotActive = pinTach_ff[`FMC_PT_PIN_HI] && processor_hot_input;

  // lock level from first config register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pinTach_ff <= `FMC_RST_PIN_TACH;
    end else if (regWrEn && regAddr == `FMC_OFS_PIN_TACH) begin
      if (globalLock) begin
        pinTach_ff <= (pinTach_ff & ~`FMC_PT_UNLOCKED_MASK) | (regWrData & `FMC_PT_UNLOCKED_MASK);
      end else begin
        pinTach_ff <= regWrData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      chanSel_ff <= `FMC_RST_CHAN_SEL;
    end else if (regWrEn && regAddr == `FMC_OFS_CHAN_SEL) begin
      chanSel_ff <= regWrData[5:0];
    end
  end

  // fan 2 keeps max at bit 7 like fan 1
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fanAAuto_ff <= `FMC_RST_FAN_AUTO;
      fanBAuto_ff <= `FMC_RST_FAN_AUTO;
    end else if (regWrEn) begin
      if (regAddr == `FMC_OFS_FAN_A_AUTO) fanAAuto_ff <= regWrData;
      if (regAddr == `FMC_OFS_FAN_B_AUTO) fanBAuto_ff <= regWrData;
    end
  end

  // track which high bytes were read since freeze
  always_comb begin
    nxt_highRead = highRead_ff;
    if (regRdEn) begin
      if (regAddr == `FMC_OFS_IN_A_HIGH) nxt_highRead[0] = 1'b1;
      if (regAddr == `FMC_OFS_IN_B_HIGH) nxt_highRead[1] = 1'b1;
      if (regAddr == `FMC_OFS_SUPPLY_HIGH) nxt_highRead[2] = 1'b1;
      if (regAddr == `FMC_OFS_REMOTE_HIGH) nxt_highRead[3] = 1'b1;
    end
  end

  // low-bits read freezes, all high reads release
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frozen_ff <= 1'b0;
      highRead_ff <= 4'h0;
    end else if (regRdEn && regAddr == `FMC_OFS_LOW_BITS) begin
      frozen_ff <= 1'b1;
      highRead_ff <= 4'h0;
    end else if (frozen_ff) begin
      frozen_ff <= nxt_highRead != `FMC_HIGH_ALL_READ;
      highRead_ff <= nxt_highRead;
    end
  end

  // low bits packed; shadows follow readings while thawed
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lowBits_ff <= `FMC_RST_READING;
      highInA_ff <= `FMC_RST_READING;
      highInB_ff <= `FMC_RST_READING;
      highSupply_ff <= `FMC_RST_READING;
      highRemote_ff <= `FMC_RST_READING;
    end else if (!frozen_ff && !(regRdEn && regAddr == `FMC_OFS_LOW_BITS)) begin
      lowBits_ff <= {analogInputAReading[1:0], analogInputBReading[1:0], supplyReading[1:0],
                     remoteReading[1:0]};
      highInA_ff <= analogInputAReading[9:2];
      highInB_ff <= analogInputBReading[9:2];
      highSupply_ff <= supplyReading[9:2];
      highRemote_ff <= remoteReading[9:2];
    end
  end

  always_comb begin
    case (regAddr)
      `FMC_OFS_PIN_TACH: nxt_regRdData = pinTach_ff;
      `FMC_OFS_CHAN_SEL: nxt_regRdData = {2'b00, chanSel_ff};
      `FMC_OFS_FAN_A_AUTO: nxt_regRdData = fanAAuto_ff;
      `FMC_OFS_FAN_B_AUTO: nxt_regRdData = fanBAuto_ff;
      `FMC_OFS_LOW_BITS: nxt_regRdData = lowBits_ff;
      `FMC_OFS_IN_A_HIGH: nxt_regRdData = highInA_ff;
      `FMC_OFS_IN_B_HIGH: nxt_regRdData = highInB_ff;
      `FMC_OFS_SUPPLY_HIGH: nxt_regRdData = highSupply_ff;
      `FMC_OFS_REMOTE_HIGH: nxt_regRdData = highRemote_ff;
      default: nxt_regRdData = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= nxt_regRdData;
    end
  end

  assign tachPeriod = pinTach_ff[`FMC_PT_FAST] ? TACH_FAST_CYC : TACH_SLOW_CYC;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tachCnt_ff <= 32'h0;
      tachSampleStrb <= 1'b0;
    end else if (tachCnt_ff >= tachPeriod - 32'h1) begin
      tachCnt_ff <= 32'h0;
      tachSampleStrb <= 1'b1;
    end else begin
      tachCnt_ff <= tachCnt_ff + 32'h1;
      tachSampleStrb <= 1'b0;
    end
  end

  // fan duty from the shared function keeps both channels identical
  always_comb begin
    nxt_fanADuty = fanDuty(fanAAuto_ff, fanAMinSpeed, fanASpinupSpeed, fan_a_drive_level,
                           chanSel_ff[`FMC_CS_FLOOR_A]);
    nxt_fanBDuty = fanDuty(fanBAuto_ff, fanBMinSpeed, fanBSpinupSpeed, fan_b_drive_level,
                           chanSel_ff[`FMC_CS_FLOOR_B]);
    if (pinTach_ff[`FMC_PT_BOOST] && procHotActive) begin
      nxt_fanADuty = `FMC_FULL_DUTY;
      nxt_fanBDuty = `FMC_FULL_DUTY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fanADuty <= 8'h00;
      fanBDuty <= 8'h00;
    end else begin
      fanADuty <= nxt_fanADuty;
      fanBDuty <= nxt_fanBDuty;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fan_a_on_output_en <= 1'b1;
      thermal_alarm_pin_en <= 1'b0;
      processor_hot_input_en <= 1'b0;
    end else begin
      fan_a_on_output_en <= pinTach_ff[1:0] == FMC_PIN_FAN_ON;
      thermal_alarm_pin_en <= pinTach_ff[1:0] == FMC_PIN_ALARM;
      processor_hot_input_en <= pinTach_ff[`FMC_PT_PIN_HI];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      continuous_speed_sense_a <= 1'b0;
      continuous_speed_sense_b <= 1'b0;
      inputAThermistor <= 1'b0;
      inputBThermistor <= 1'b0;
      diodePairMode <= 1'b0;
      one_channel_conversion <= 1'b0;
      single_conversion_channel <= 3'h0;
    end else begin
      continuous_speed_sense_a <= pinTach_ff[`FMC_PT_CONT_A];
      continuous_speed_sense_b <= pinTach_ff[`FMC_PT_CONT_B];
      inputAThermistor <= pinTach_ff[`FMC_PT_THERMAL_ALARM_PIN_A] && !second_diode_mode;
      inputBThermistor <= pinTach_ff[`FMC_PT_THERMAL_ALARM_PIN_B] && !second_diode_mode;
      diodePairMode <= second_diode_mode;
      one_channel_conversion <= chanSel_ff[`FMC_CS_SINGLE];
      single_conversion_channel <= chanSel_ff[`FMC_CS_CHAN_HI:`FMC_CS_CHAN_LO];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_lockedWrite;
    globalLock && regWrEn && regAddr == `FMC_OFS_PIN_TACH;
  endsequence

  property p_lockHolds;
    s_lockedWrite |=> pinTach_ff[3:0] == $past(pinTach_ff[3:0]) && pinTach_ff[7:6] == $past(pinTach_ff[7:6]);
  endproperty
  a_lockHolds: assert property (p_lockHolds) else $error("locked bits changed");

  property p_contWritable;
    s_lockedWrite |=> pinTach_ff[5:4] == $past(regWrData[5:4]);
  endproperty
  a_contWritable: assert property (p_contWritable) else $error("tach bits not written");

  property p_boost;
    pinTach_ff[`FMC_PT_BOOST] && pinTach_ff[`FMC_PT_PIN_HI] && processor_hot_input
      |=> fanADuty == `FMC_FULL_DUTY && fanBDuty == `FMC_FULL_DUTY;
  endproperty
  a_boost: assert property (p_boost) else $error("boost not full duty");

  property p_chanZero;
    regRdEn && regAddr == `FMC_OFS_CHAN_SEL |=> regRdData[7:6] == 2'b00;
  endproperty
  a_chanZero: assert property (p_chanZero) else $error("reserved bits nonzero");

  property p_maxWins;
    fanBAuto_ff[`FMC_AC_MAX] && !(pinTach_ff[`FMC_PT_BOOST] && procHotActive) |=> fanBDuty == `FMC_FULL_DUTY;
  endproperty
  a_maxWins: assert property (p_maxWins) else $error("max speed not applied");

  property p_floor;
    chanSel_ff[`FMC_CS_FLOOR_A] |=> fanADuty >= $past(fanAMinSpeed);
  endproperty
  a_floor: assert property (p_floor) else $error("fan below floor");

  sequence s_freeze;
    regRdEn && regAddr == `FMC_OFS_LOW_BITS;
  endsequence

  property p_freeze;
    s_freeze ##1 !regRdEn |=> $stable(lowBits_ff) && $stable(highRemote_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("readings moved while frozen");

  property p_pinDecode;
    pinTach_ff[1:0] == 2'b01 |=> thermal_alarm_pin_en && !fan_a_on_output_en && !processor_hot_input_en;
  endproperty
  a_pinDecode: assert property (p_pinDecode) else $error("pin decode wrong");

  property p_diode;
    second_diode_mode |=> !inputAThermistor && !inputBThermistor && diodePairMode;
  endproperty
  a_diode: assert property (p_diode) else $error("diode override failed");
endmodule : fmc_config_regs
`default_nettype wire

// [fmc_host_model.sv]
// fmc_host_model.sv: host side of the byte register port
// assumes: one-cycle strobes, read data registered one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module fmc_host_model (
  input wire logic ref_clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'hff;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // released lines show inverted values so a stale bus never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr
  // data sampled mid-cycle after the registered answer lands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    @(negedge ref_clk);
    d = regRdData;
  endtask : rd
endmodule : fmc_host_model
`default_nettype wire

// [tb_top.sv]
// tb_top.sv: self-checking bench for the fan monitor configuration bank
// assumes: fmc_host_model drives the register port, bench drives all levels
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fmc_pkg::*;
  localparam int SLOW = 40;
  localparam int FAST = 10;
  logic ref_clk, rst_b, regWrEn, regRdEn, globalLock, second_diode_mode, processor_hot_input;
  logic [7:0] regAddr, regWrData, regRdData, demA, demB, demR, demO, minA, minB, spinA, spinB, drvA, drvB;
  logic [9:0] remRd, supRd, inARd, inBRd;
  logic pinFanOn, pinAlarm, pinHot, tachStrb, contA, contB, thermA, thermB, diodePair, oneChan;
  logic [2:0] chan;
  logic [7:0] dutyA, dutyB;
  int errorCnt = 0;
  int cmpCount = 0;

  fmc_host_model u_fmc_host_model (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
  fmc_config_regs #(.TACH_SLOW_CYC(SLOW), .TACH_FAST_CYC(FAST)) u_fmc_config_regs (
    .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .globalLock(globalLock), .second_diode_mode(second_diode_mode),
    .processor_hot_input(processor_hot_input), .remoteReading(remRd), .supplyReading(supRd),
    .analogInputAReading(inARd), .analogInputBReading(inBRd), .inputADemand(demA), .inputBDemand(demB),
    .remoteDemand(demR), .onchipDemand(demO), .fanAMinSpeed(minA), .fanBMinSpeed(minB),
    .fanASpinupSpeed(spinA), .fanBSpinupSpeed(spinB), .fan_a_drive_level(drvA), .fan_b_drive_level(drvB),
    .fan_a_on_output_en(pinFanOn), .thermal_alarm_pin_en(pinAlarm), .processor_hot_input_en(pinHot),
    .tachSampleStrb(tachStrb), .continuous_speed_sense_a(contA), .continuous_speed_sense_b(contB),
    .inputAThermistor(thermA), .inputBThermistor(thermB), .diodePairMode(diodePair),
    .one_channel_conversion(oneChan), .single_conversion_channel(chan), .fanADuty(dutyA), .fanBDuty(dutyB));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_fmc_host_model.rd(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask : rdChk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_fmc_host_model.wr(a, d);
    repeat (3) @(negedge ref_clk);
  endtask : wr
  // period in cycles between two strobes, bounded so a dead strobe cannot hang
  task automatic measure(output int n);
    for (int i = 0; i < 200 && tachStrb !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    n = 1;
    while (tachStrb !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : measure
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge ref_clk);
    errorCnt++;
    results();
  end

  initial begin
    logic [7:0] ctl[10];
    logic [7:0] exp[10];
    logic [9:0] o[4];
    int n;
    {rst_b, globalLock, second_diode_mode, processor_hot_input} = 4'b0000;
    {remRd, supRd, inARd, inBRd} = '0;
    {demA, demB, demR, demO} = {8'h10, 8'h20, 8'h30, 8'h40};
    {minA, minB, spinA, spinB, drvA, drvB} = {8'h18, 8'h19, 8'h50, 8'h51, 8'h60, 8'h61};
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("fan on pin", 8'h01, {7'h0, pinFanOn});
    rdChk(8'h02, 8'hc0);
    rdChk(8'h03, 8'h00);
    rdChk(8'h05, 8'h0c);
    rdChk(8'h06, 8'h0c);
    rdChk(8'h04, 8'h00);
    wr(8'h08, 8'hff);
    rdChk(8'h08, 8'h00);
    for (int i = 0; i < 4; i++) rdChk(8'(8'h0a + i), 8'h00);
    // tach interval both rates
    measure(n);
    chk("tach slow", 8'(SLOW), 8'(n));
    wr(8'h02, 8'hc8);
    measure(n);
    measure(n);
    chk("tach fast", 8'(FAST), 8'(n));
    // fan priority table, same for both fans
    ctl = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h0c, 8'h10, 8'h30, 8'h70, 8'hf0};
    for (int f = 0; f < 2; f++) begin
      exp = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h20, 8'h40, f ? drvB : drvA, f ? minB : minA,
        f ? spinB : spinA, 8'hff};
      for (int i = 0; i < 10; i++) begin
        wr(f ? 8'h06 : 8'h05, ctl[i]);
        chk($sformatf("duty fan %0d ctl %h", f, ctl[i]), exp[i], f ? dutyB : dutyA);
      end
    end
    wr(8'h05, 8'h01);
    wr(8'h06, 8'h01);
    wr(8'h03, 8'h30);
    chk("floor a", minA, dutyA);
    chk("floor b", minB, dutyB);
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h40);
    wr(8'h05, 8'h03);
    chk("input b analog", 8'h10, dutyA);
    @(posedge ref_clk) second_diode_mode <= 1'b1;
    wr(8'h02, 8'h80);
    wr(8'h05, 8'h01);
    chk("diode pair src", 8'h10, dutyA);
    chk("thermal_alarm_pin a off", 8'h00, {7'h0, thermA});
    chk("thermal_alarm_pin b off", 8'h00, {7'h0, thermB});
    chk("pair mode", 8'h01, {7'h0, diodePair});
    @(posedge ref_clk) second_diode_mode <= 1'b0;
    wr(8'h02, 8'h50);
    chk("cont bits 50", 8'h0a, {4'h0, contA, contB, thermA, thermB});
    wr(8'h02, 8'ha0);
    chk("cont bits a0", 8'h05, {4'h0, contA, contB, thermA, thermB});
    rdChk(8'h02, 8'ha0);
    for (int p = 0; p < 4; p++) begin
      wr(8'h02, {6'h30, 2'(p)});
      chk("pin function", {5'h0, 1'(p == 0), 1'(p == 1), 1'(p >= 2)}, {5'h0, pinFanOn, pinAlarm, pinHot});
    end
    wr(8'h02, 8'hc6);
    @(posedge ref_clk) processor_hot_input <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("boost a", 8'hff, dutyA);
    chk("boost b", 8'hff, dutyB);
    @(posedge ref_clk) processor_hot_input <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("boost off", 8'h10, dutyA);
    wr(8'h03, 8'hff);
    rdChk(8'h03, 8'h3f);
    chk("single chan", 8'h0f, {4'h0, oneChan, chan});
    for (int c = 3; c < 6; c++) begin
      wr(8'h03, {5'h01, 3'(c)});
      chk("channel", 8'(c), {5'h0, chan});
    end
    @(posedge ref_clk) globalLock <= 1'b1;
    wr(8'h02, 8'h31);
    rdChk(8'h02, 8'hf6);
    wr(8'h02, 8'hc6);
    rdChk(8'h02, 8'hc6);
    // low bits read first freezes the high bytes
    o = '{10'h3c5, 10'h20a, 10'h10f, 10'h2c0};
    @(posedge ref_clk) {inARd, inBRd, supRd, remRd} <= {o[0], o[1], o[2], o[3]};
    repeat (3) @(negedge ref_clk);
    rdChk(8'h08, {o[0][1:0], o[1][1:0], o[2][1:0], o[3][1:0]});
    @(posedge ref_clk) {inARd, inBRd, supRd, remRd} <= ~{o[0], o[1], o[2], o[3]};
    for (int i = 0; i < 4; i++) rdChk(8'(8'h0a + i), o[i][9:2]);
    repeat (3) @(negedge ref_clk);
    rdChk(8'h08, ~{o[0][1:0], o[1][1:0], o[2][1:0], o[3][1:0]});
    rdChk(8'h0a, ~o[0][9:2]);
    results();
  end
endmodule : tb_top
`default_nettype wire
